// ===== pkg/ssck_regs.vh
// Register map, field positions, reset values and response codes of the serial clocking core.
// Included by the design file; definitions only.
`ifndef SSCK_REGS_VH
`define SSCK_REGS_VH

`define SSCK_DIV_MODE_OFF 8'h00
`define SSCK_TX_CLK_MODE_OFF 8'h04
`define SSCK_RX_CLK_MODE_OFF 8'h08
`define SSCK_CTRL_OFF 8'h0c
`define SSCK_STATUS_OFF 8'h10
`define SSCK_IRQ_MASK_OFF 8'h14
`define SSCK_TX_DATA_OFF 8'h18
`define SSCK_RX_DATA_OFF 8'h1c

`define SSCK_DIV_W 12
`define SSCK_DIV_RST 12'h000

// Clock mode register fields
`define SSCK_CKS_LSB 0
`define SSCK_CKS_EXT 2'h0
`define SSCK_CKS_OTHER 2'h1
`define SSCK_CKS_DIV 2'h2
`define SSCK_CKO_LSB 2
`define SSCK_CKO_NONE 2'h0
`define SSCK_CKO_CONT 2'h1
`define SSCK_CKO_XFER 2'h2
`define SSCK_CKI_BIT 5
`define SSCK_START_LSB 8
`define SSCK_ST_CONT 3'h0
`define SSCK_ST_OTHER 3'h1
`define SSCK_ST_LOW 3'h2
`define SSCK_ST_HIGH 3'h3
`define SSCK_ST_FALL 3'h4
`define SSCK_ST_RISE 3'h5
`define SSCK_ST_LEVEL 3'h6
`define SSCK_ST_ANY 3'h7
`define SSCK_CMR_RST 16'h0000
`define SSCK_CMR_MASK 32'h0000073f

// Control bits
`define SSCK_CTRL_TXEN 0
`define SSCK_CTRL_RXEN 1

// Status / interrupt bits
`define SSCK_ST_TXRDY 0
`define SSCK_ST_RXRDY 1
`define SSCK_ST_TXSTART 2
`define SSCK_ST_RXSTART 3
`define SSCK_IRQ_W 4

`define SSCK_RESP_OKAY 2'h0
`define SSCK_RESP_SLVERR 2'h2

`endif

// ===== design/ssck_core.v
// Clocking core of a synchronous serial controller: divider, clock selection,
// pad drive, start detection, word transfer to and from the link, AXI4-Lite registers.
// Assumes pad inputs are synchronous to ref_clk_i and pad clocks run below half of it.
//
// How it works
// - Transmitter and receiver run independently; one shared divider serves both.
// - Each direction has data, a two-way bit clock and a frame-sync used as input only, its pad outputs tied off.
// - Each direction starts continuously, with the other side, or on frame-sync events.
// - Transmit clock comes from its pad, the receive clock, or the divider.
// - Receive clock comes from its pad, the transmit clock, or the divider.
// - Each direction may drive its own clock pad as an output.
// - Divider setting is twelve bits, up to 4095, ratio up to 8190.
// - A zero setting keeps the divider idle with no output clock.
// - Divided clock frequency is master clock over twice the setting.
// - High and low phases each last exactly setting master-clock cycles.
// - One divided clock feeds both clock selectors.
// - Transmit clock mode register selects and optionally inverts the transmit clock.
// - Inversion acts on the internal clock only, never on driven pads.
// - Clock pad is driven continuously or only during a transfer.
// - Each side may borrow the other's clock and start.
// - Interrupt line asserts when any pending source is unmasked.
// - Status register shows which source is pending.
// - Each source has its own mask bit.
// - Two transfer channels of 32-bit words, one per direction.
// - Receive clock mode register selects and optionally inverts the receive clock.
`timescale 1ns/100ps
`include "ssck_regs.vh"

module ssck_core #(
    parameter WORD_W = 32
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire tx_serial_out_o,
    input wire rx_serial_in_i,
    input wire tx_bit_clock_pad_i,
    output wire tx_bit_clock_pad_o,
    output wire tx_bit_clock_pad_oe_o,
    input wire rx_bit_clock_pad_i,
    output wire rx_bit_clock_pad_o,
    output wire rx_bit_clock_pad_oe_o,
    input wire tx_frame_sync_pad_i,
    output wire tx_frame_sync_pad_o,
    output wire tx_frame_sync_pad_oe_o,
    input wire rx_frame_sync_pad_i,
    output wire rx_frame_sync_pad_o,
    output wire rx_frame_sync_pad_oe_o,
    input wire tx_chan_valid_i,
    output wire tx_chan_ready_o,
    input wire [WORD_W-1:0] tx_chan_data_i,
    output wire rx_chan_valid_o,
    input wire rx_chan_ready_i,
    output wire [WORD_W-1:0] rx_chan_data_o,
    output wire irq_o
);

    localparam [5:0] CNT_W = 6;

    reg [`SSCK_DIV_W-1:0] div_q;
    reg [15:0] tcmr_q;
    reg [15:0] rcmr_q;
    reg [1:0] ctrl_q;
    reg [`SSCK_IRQ_W-1:0] status_q;
    reg [`SSCK_IRQ_W-1:0] mask_q;
    reg [`SSCK_DIV_W-1:0] dcnt_q;
    reg dclk_q;
    reg [WORD_W-1:0] tx_hold_q;
    reg tx_full_q;
    reg [WORD_W-1:0] tx_shift_q;
    reg [CNT_W-1:0] tx_cnt_q;
    reg tx_busy_q;
    reg [WORD_W-1:0] rx_shift_q;
    reg [CNT_W-1:0] rx_cnt_q;
    reg rx_busy_q;
    reg [WORD_W-1:0] rx_data_q;
    reg rx_full_q;
    reg tclk_prev_q;
    reg rclk_prev_q;
    reg tfs_prev_q;
    reg rfs_prev_q;
    reg tx_out_q;
    reg aw_got_q;
    reg w_got_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    // Divider: counts from zero to one below the setting then flips, so each phase lasts exactly the setting
    wire div_wr;
    wire div_on = (div_q != `SSCK_DIV_RST);
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dcnt_q <= `SSCK_DIV_RST;
            dclk_q <= 1'b0;
        end else if (div_wr || !div_on) begin
            dcnt_q <= `SSCK_DIV_RST;
            dclk_q <= 1'b0;
        end else if (dcnt_q == div_q - 12'h001) begin
            dcnt_q <= `SSCK_DIV_RST;
            dclk_q <= ~dclk_q;
        end else begin
            dcnt_q <= dcnt_q + 12'h001;
        end
    end

    // Clock selection; the base pad-or-divider clocks feed each other to avoid a loop
    wire [1:0] t_cks = tcmr_q[`SSCK_CKS_LSB+1:`SSCK_CKS_LSB];
    wire [1:0] r_cks = rcmr_q[`SSCK_CKS_LSB+1:`SSCK_CKS_LSB];
    wire tclk_raw_base = (t_cks == `SSCK_CKS_DIV) ? dclk_q : tx_bit_clock_pad_i;
    wire rclk_raw_base = (r_cks == `SSCK_CKS_DIV) ? dclk_q : rx_bit_clock_pad_i;
    wire tclk_raw = (t_cks == `SSCK_CKS_OTHER) ? rclk_raw_base : tclk_raw_base;
    wire rclk_raw = (r_cks == `SSCK_CKS_OTHER) ? tclk_raw_base : rclk_raw_base;
    wire tclk = tclk_raw ^ tcmr_q[`SSCK_CKI_BIT];
    wire rclk = rclk_raw ^ rcmr_q[`SSCK_CKI_BIT];
    wire t_rise = tclk && !tclk_prev_q;
    wire t_fall = !tclk && tclk_prev_q;
    wire r_rise = rclk && !rclk_prev_q;

    // Pads carry the uninverted clock; driving a pad fed from itself is left to software
    wire [1:0] t_cko = tcmr_q[`SSCK_CKO_LSB+1:`SSCK_CKO_LSB];
    wire [1:0] r_cko = rcmr_q[`SSCK_CKO_LSB+1:`SSCK_CKO_LSB];
    assign tx_bit_clock_pad_o = tclk_raw;
    assign rx_bit_clock_pad_o = rclk_raw;
    assign tx_bit_clock_pad_oe_o = (t_cko == `SSCK_CKO_CONT) || ((t_cko == `SSCK_CKO_XFER) && tx_busy_q);
    assign rx_bit_clock_pad_oe_o = (r_cko == `SSCK_CKO_CONT) || ((r_cko == `SSCK_CKO_XFER) && rx_busy_q);
    // Frame-sync lines are inputs here; waveform generation lives elsewhere
    assign tx_frame_sync_pad_o = 1'b0;
    assign tx_frame_sync_pad_oe_o = 1'b0;
    assign rx_frame_sync_pad_o = 1'b0;
    assign rx_frame_sync_pad_oe_o = 1'b0;

    // Start events per direction
    function start_hit;
        input [2:0] sel;
        input fs;
        input fs_prev;
        input other;
        begin
            case (sel)
                `SSCK_ST_CONT: start_hit = 1'b1;
                `SSCK_ST_OTHER: start_hit = other;
                `SSCK_ST_LOW: start_hit = !fs;
                `SSCK_ST_HIGH: start_hit = fs;
                `SSCK_ST_FALL: start_hit = fs_prev && !fs;
                `SSCK_ST_RISE: start_hit = !fs_prev && fs;
                default: start_hit = fs != fs_prev;
            endcase
        end
    endfunction

    wire tx_go = ctrl_q[`SSCK_CTRL_TXEN] && !tx_busy_q && tx_full_q && t_fall;
    wire rx_go = ctrl_q[`SSCK_CTRL_RXEN] && !rx_busy_q && r_rise;
    wire tx_start = tx_go && start_hit(tcmr_q[`SSCK_START_LSB+2:`SSCK_START_LSB],
        tx_frame_sync_pad_i, tfs_prev_q, rx_busy_q);
    wire rx_start = rx_go && start_hit(rcmr_q[`SSCK_START_LSB+2:`SSCK_START_LSB],
        rx_frame_sync_pad_i, rfs_prev_q, tx_busy_q);

    // Transmit channel, holding register and shifter
    wire tx_take = tx_chan_valid_i && !tx_full_q;
    assign tx_chan_ready_o = !tx_full_q;
    wire tx_done = tx_busy_q && t_fall && (tx_cnt_q == WORD_W - 1);
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_hold_q <= {WORD_W{1'b0}};
            tx_full_q <= 1'b0;
            tx_shift_q <= {WORD_W{1'b0}};
            tx_cnt_q <= {CNT_W{1'b0}};
            tx_busy_q <= 1'b0;
            tx_out_q <= 1'b0;
            tclk_prev_q <= 1'b0;
            tfs_prev_q <= 1'b0;
        end else begin
            tclk_prev_q <= tclk;
            tfs_prev_q <= tx_frame_sync_pad_i;
            if (tx_start) begin
                tx_shift_q <= {tx_hold_q[WORD_W-2:0], 1'b0};
                tx_out_q <= tx_hold_q[WORD_W-1];
                tx_full_q <= 1'b0;
                tx_busy_q <= 1'b1;
                tx_cnt_q <= {CNT_W{1'b0}};
            end else begin
                if (tx_take) begin
                    tx_hold_q <= tx_chan_data_i;
                    tx_full_q <= 1'b1;
                end
                if (tx_done) begin
                    tx_busy_q <= 1'b0;
                end else if (tx_busy_q && t_fall) begin
                    tx_out_q <= tx_shift_q[WORD_W-1];
                    tx_shift_q <= {tx_shift_q[WORD_W-2:0], 1'b0};
                    tx_cnt_q <= tx_cnt_q + 6'h01;
                end
            end
        end
    end
    assign tx_serial_out_o = tx_out_q;

    // Receive shifter and holding register; an unread word is overwritten
    wire rx_last = rx_busy_q && r_rise && (rx_cnt_q == WORD_W - 1);
    assign rx_chan_valid_o = rx_full_q;
    assign rx_chan_data_o = rx_data_q;
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_shift_q <= {WORD_W{1'b0}};
            rx_cnt_q <= {CNT_W{1'b0}};
            rx_busy_q <= 1'b0;
            rx_data_q <= {WORD_W{1'b0}};
            rx_full_q <= 1'b0;
            rclk_prev_q <= 1'b0;
            rfs_prev_q <= 1'b0;
        end else begin
            rclk_prev_q <= rclk;
            rfs_prev_q <= rx_frame_sync_pad_i;
            if (rx_start) begin
                rx_shift_q <= {{(WORD_W-1){1'b0}}, rx_serial_in_i};
                rx_cnt_q <= 6'h01;
                rx_busy_q <= 1'b1;
            end else if (rx_busy_q && r_rise) begin
                rx_shift_q <= {rx_shift_q[WORD_W-2:0], rx_serial_in_i};
                rx_cnt_q <= rx_cnt_q + 6'h01;
                if (rx_cnt_q == WORD_W - 1)
                    rx_busy_q <= 1'b0;
            end
            if (rx_last) begin
                rx_data_q <= {rx_shift_q[WORD_W-2:0], rx_serial_in_i};
                rx_full_q <= 1'b1;
            end else if (rx_full_q && rx_chan_ready_i) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // AXI4-Lite slave: one write and one read at a time
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
    wire [7:0] wa = awaddr_q;
    assign div_wr = wr_fire && (wa == `SSCK_DIV_MODE_OFF);
    wire st_clr = wr_fire && (wa == `SSCK_STATUS_OFF);
    wire [31:0] cmr_wr = wdata_q & `SSCK_CMR_MASK;
    wire [`SSCK_IRQ_W-1:0] ev = {rx_start, tx_start, rx_last, tx_start};

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            bvalid_q <= 1'b0;
            bresp_q <= `SSCK_RESP_OKAY;
            div_q <= `SSCK_DIV_RST;
            tcmr_q <= `SSCK_CMR_RST;
            rcmr_q <= `SSCK_CMR_RST;
            ctrl_q <= 2'h0;
            mask_q <= 4'h0;
            status_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
            // Status is write-one-to-clear; a new event in the same cycle wins
            status_q <= (status_q & ~(st_clr ? wdata_q[`SSCK_IRQ_W-1:0] : 4'h0)) | ev;
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= `SSCK_RESP_OKAY;
                if (wa == `SSCK_DIV_MODE_OFF) begin
                    div_q <= wdata_q[`SSCK_DIV_W-1:0];
                end else if (wa == `SSCK_TX_CLK_MODE_OFF) begin
                    tcmr_q <= cmr_wr[15:0];
                end else if (wa == `SSCK_RX_CLK_MODE_OFF) begin
                    rcmr_q <= cmr_wr[15:0];
                end else if (wa == `SSCK_CTRL_OFF) begin
                    ctrl_q <= wdata_q[1:0];
                end else if (wa == `SSCK_IRQ_MASK_OFF) begin
                    mask_q <= wdata_q[`SSCK_IRQ_W-1:0];
                end else if (wa != `SSCK_STATUS_OFF) begin
                    bresp_q <= `SSCK_RESP_SLVERR;
                end
            end
        end
    end

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `SSCK_RESP_OKAY;
        end else if (rvalid_q) begin
            if (s_axi_rready)
                rvalid_q <= 1'b0;
        end else if (s_axi_arvalid) begin
            rvalid_q <= 1'b1;
            rresp_q <= `SSCK_RESP_OKAY;
            rdata_q <= 32'h00000000;
            if (s_axi_araddr == `SSCK_DIV_MODE_OFF) begin
                rdata_q <= {20'h00000, div_q};
            end else if (s_axi_araddr == `SSCK_TX_CLK_MODE_OFF) begin
                rdata_q <= {16'h0000, tcmr_q};
            end else if (s_axi_araddr == `SSCK_RX_CLK_MODE_OFF) begin
                rdata_q <= {16'h0000, rcmr_q};
            end else if (s_axi_araddr == `SSCK_CTRL_OFF) begin
                rdata_q <= {30'h00000000, ctrl_q};
            end else if (s_axi_araddr == `SSCK_STATUS_OFF) begin
                rdata_q <= {26'h0000000, rx_busy_q, tx_busy_q, status_q};
            end else if (s_axi_araddr == `SSCK_IRQ_MASK_OFF) begin
                rdata_q <= {28'h0000000, mask_q};
            end else if (s_axi_araddr == `SSCK_TX_DATA_OFF) begin
                rdata_q <= tx_hold_q;
            end else if (s_axi_araddr == `SSCK_RX_DATA_OFF) begin
                rdata_q <= rx_data_q;
            end else begin
                rresp_q <= `SSCK_RESP_SLVERR;
            end
        end
    end

    assign irq_o = |(status_q & mask_q);

endmodule

// ===== bench/ssck_core_props.sv
// Checker for the serial clocking core, bound to its top-level ports.
// Assumes one ref_clk_i domain with resetn_i active low.
`timescale 1ns/100ps
module ssck_core_props #(
    parameter WORD_W = 32
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_frame_sync_pad_oe_o,
    input wire rx_frame_sync_pad_oe_o,
    input wire tx_chan_valid_i,
    input wire tx_chan_ready_o,
    input wire rx_chan_valid_o,
    input wire rx_chan_ready_i,
    input wire [WORD_W-1:0] rx_chan_data_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rx_word_hold: assert property (rx_chan_valid_o && !rx_chan_ready_i
        |=> rx_chan_valid_o && $stable(rx_chan_data_o))
        else $error("receive word not held");
    a_tx_word_full: assert property (tx_chan_valid_i && tx_chan_ready_o |=> !tx_chan_ready_o)
        else $error("holding not marked full");
    a_sync_undriven: assert property (!tx_frame_sync_pad_oe_o && !rx_frame_sync_pad_oe_o)
        else $error("frame sync pad driven");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_tx_word: cover property (tx_chan_valid_i && tx_chan_ready_o);
    c_rx_word: cover property (rx_chan_valid_o && rx_chan_ready_i);
endmodule

bind ssck_core ssck_core_props #(.WORD_W(WORD_W)) ssck_core_props_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tx_frame_sync_pad_oe_o(tx_frame_sync_pad_oe_o), .rx_frame_sync_pad_oe_o(rx_frame_sync_pad_oe_o),
    .tx_chan_valid_i(tx_chan_valid_i), .tx_chan_ready_o(tx_chan_ready_o), .rx_chan_valid_o(rx_chan_valid_o),
    .rx_chan_ready_i(rx_chan_ready_i), .rx_chan_data_o(rx_chan_data_o));

// ===== bench/ssck_codec_model.sv
// Codec on the serial side: optional bit clock, capture of transmit data, loop to receive data.
// Assumes the transmit pad clock is only looked at while its enable is high.
`timescale 1ns/100ps
module ssck_codec_model (
    input wire clk_i,
    input wire resetn_i,
    input wire ext_en_i,
    output reg ext_clk_o,
    input wire tx_clk_i,
    input wire tx_clk_oe_i,
    input wire tx_data_i,
    output wire rx_data_o,
    output reg [31:0] got_o = 32'h0
);
    reg div_q;
    // Quarter rate clock, still while disabled
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i || !ext_en_i) begin
            div_q <= 1'b0;
            ext_clk_o <= 1'b0;
        end else begin
            div_q <= ~div_q;
            if (div_q)
                ext_clk_o <= ~ext_clk_o;
        end
    end
    // Samples on rising edges only while the pad is driven
    always @(posedge tx_clk_i) begin
        if (tx_clk_oe_i)
            got_o <= {got_o[30:0], tx_data_i};
    end
    assign rx_data_o = tx_data_i;
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the serial clocking core over AXI4-Lite.
// Assumes the codec model on the pads and the bound checker.
`timescale 1ns/100ps
`include "ssck_regs.vh"
`define CHK(a, e) begin n_tests = n_tests + 1; if ((a) !== (e)) begin err_count = err_count + 1; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    reg ref_clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [31:0] wdata = 32'h0, txd = 32'h0, rv, v;
    reg txv = 1'b0, rxr = 1'b0, ext_en = 1'b0, tfs = 1'b0, pk;
    reg [1:0] rs;
    wire awready, wready, bvalid, arready, rvalid, td, echo, tck, tck_oe, rck, rck_oe, txr, rxv, irq, ext_clk;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, rxd, got;
    integer err_count = 0, n_tests = 0, cyc = 0, h, l, i, n;
    always #25 ref_clk_i = ~ref_clk_i;
    ssck_core ssck_core_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_serial_out_o(td), .rx_serial_in_i(echo), .tx_bit_clock_pad_i(ext_clk), .tx_bit_clock_pad_o(tck),
        .tx_bit_clock_pad_oe_o(tck_oe), .rx_bit_clock_pad_i(~ext_clk), .rx_bit_clock_pad_o(rck),
        .rx_bit_clock_pad_oe_o(rck_oe), .tx_frame_sync_pad_i(tfs), .tx_frame_sync_pad_o(),
        .tx_frame_sync_pad_oe_o(), .rx_frame_sync_pad_i(1'b0), .rx_frame_sync_pad_o(), .rx_frame_sync_pad_oe_o(),
        .tx_chan_valid_i(txv), .tx_chan_ready_o(txr), .tx_chan_data_i(txd), .rx_chan_valid_o(rxv),
        .rx_chan_ready_i(rxr), .rx_chan_data_o(rxd), .irq_o(irq));
    ssck_codec_model ssck_codec_model_i (.clk_i(ref_clk_i), .resetn_i(resetn_i), .ext_en_i(ext_en),
        .ext_clk_o(ext_clk), .tx_clk_i(tck), .tx_clk_oe_i(tck_oe), .tx_data_i(td), .rx_data_o(echo), .got_o(got));
    task test_done;
        begin
            if (err_count == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // Divider runs of 4095 dominate the run time
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    task wr(input [7:0] a, input [31:0] d);
        reg ta, tw, tb;
        begin
            @(posedge ref_clk_i);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            tb = 1'b0;
            while (!tb) begin
                @(negedge ref_clk_i);
                ta = awvalid & awready;
                tw = wvalid & wready;
                tb = bvalid & bready;
                rs = bresp;
                pk = tck;
                @(posedge ref_clk_i);
                if (ta)
                    awvalid <= 1'b0;
                if (tw)
                    wvalid <= 1'b0;
                if (tb)
                    bready <= 1'b0;
            end
        end
    endtask
    task rd(input [7:0] a);
        reg ta, tb;
        begin
            @(posedge ref_clk_i);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            tb = 1'b0;
            while (!tb) begin
                @(negedge ref_clk_i);
                ta = arvalid & arready;
                tb = rvalid & rready;
                rv = rdata;
                rs = rresp;
                @(posedge ref_clk_i);
                if (ta)
                    arvalid <= 1'b0;
                if (tb)
                    rready <= 1'b0;
            end
        end
    endtask
    task phase;
        begin
            h = 0;
            l = 0;
            @(negedge ref_clk_i);
            while (tck !== 1'b0) @(negedge ref_clk_i);
            while (tck !== 1'b1) @(negedge ref_clk_i);
            while (tck === 1'b1) begin
                h = h + 1;
                @(negedge ref_clk_i);
            end
            while (tck === 1'b0) begin
                l = l + 1;
                @(negedge ref_clk_i);
            end
        end
    endtask
    task xfer(input [31:0] w);
        reg t;
        begin
            @(posedge ref_clk_i);
            txd <= w;
            txv <= 1'b1;
            t = 1'b0;
            while (!t) begin
                @(negedge ref_clk_i);
                t = txv & txr;
                @(posedge ref_clk_i);
                if (t)
                    txv <= 1'b0;
            end
            h = 0;
            while (rxv !== 1'b1) begin
                @(negedge ref_clk_i);
                if (ext_en && tck_oe === 1'b1 && tck !== ext_clk)
                    h = h + 1;
            end
            `CHK(rxd, w)
            `CHK(got, w)
            `CHK(h, 0)
            @(posedge ref_clk_i);
            rxr <= 1'b1;
            @(posedge ref_clk_i);
            rxr <= 1'b0;
            repeat (8) @(negedge ref_clk_i);
            `CHK(tck_oe, 1'b0)
        end
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            rd(8'(i * 4));
            `CHK(rv, 32'h0)
        end
        rd(8'h20);
        `CHK(rs, `SSCK_RESP_SLVERR)
        wr(8'h20, 32'h1);
        `CHK(rs, `SSCK_RESP_SLVERR)
        for (i = 0; i < 8; i = i + 1) begin
            v = (i << 8) | (i % 3) | ((i % 3) << 2) | ((i & 1) << 5);
            wr(`SSCK_RX_CLK_MODE_OFF, v);
            rd(`SSCK_RX_CLK_MODE_OFF);
            `CHK(rv, v)
        end
        wr(`SSCK_TX_CLK_MODE_OFF, 32'hffffffff);
        rd(`SSCK_TX_CLK_MODE_OFF);
        `CHK(rv, `SSCK_CMR_MASK)
        wr(`SSCK_DIV_MODE_OFF, 32'h1fff);
        rd(`SSCK_DIV_MODE_OFF);
        `CHK(rv, 32'h0fff)
        wr(`SSCK_RX_CLK_MODE_OFF, 32'h06);
        for (i = 0; i < 4; i = i + 1) begin
            n = (i == 3) ? 4095 : i + 1;
            wr(`SSCK_TX_CLK_MODE_OFF, 32'h06 | ((i & 1) << 5));
            wr(`SSCK_DIV_MODE_OFF, n);
            `CHK(pk, 1'b0)
            phase;
            `CHK(h, n)
            `CHK(l, n)
            `CHK(rck, tck)
            `CHK(rck_oe, 1'b1)
        end
        wr(`SSCK_DIV_MODE_OFF, 32'h0);
        h = 0;
        repeat (20) begin
            @(negedge ref_clk_i);
            if (tck !== 1'b0)
                h = h + 1;
        end
        `CHK(h, 0)
        wr(`SSCK_DIV_MODE_OFF, 32'h2);
        wr(`SSCK_TX_CLK_MODE_OFF, 32'h0a);
        wr(`SSCK_RX_CLK_MODE_OFF, 32'h109);
        wr(`SSCK_CTRL_OFF, 32'h3);
        wr(`SSCK_IRQ_MASK_OFF, 32'h0);
        `CHK(tck_oe, 1'b0)
        xfer(32'ha5c31e69);
        rd(`SSCK_STATUS_OFF);
        `CHK(rv & 32'hf, 32'hf)
        `CHK(irq, 1'b0)
        wr(`SSCK_IRQ_MASK_OFF, 32'h2);
        @(negedge ref_clk_i);
        `CHK(irq, 1'b1)
        wr(`SSCK_STATUS_OFF, 32'hf);
        rd(`SSCK_STATUS_OFF);
        `CHK(rv & 32'hf, 32'h0)
        `CHK(irq, 1'b0)
        ext_en <= 1'b1;
        // Pad source with transfer-only drive, never continuous; start waits for frame-sync high
        wr(`SSCK_TX_CLK_MODE_OFF, 32'h328);
        fork
            xfer(32'h3c96f00f);
            begin
                repeat (40) @(negedge ref_clk_i);
                `CHK(tck_oe, 1'b0)
                @(posedge ref_clk_i);
                tfs <= 1'b1;
            end
        join
        wr(`SSCK_RX_CLK_MODE_OFF, 32'h0);
        wr(`SSCK_TX_CLK_MODE_OFF, 32'h1);
        @(negedge ref_clk_i);
        `CHK(rck, ~ext_clk)
        `CHK(tck, ~ext_clk)
        test_done;
    end
endmodule
